// [ctpr_pkg.sv]
// Constants shared by the cascadable timer pair and its tick generator.
// Assumes a 16-bit register port with word indices as addresses.
package ctpr_pkg;

	// ------------------------------------------------------------
	// Register word indices on the register port.
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] LOW_CTL_ADDR = 4'h0;
	localparam logic [3:0] HIGH_CTL_ADDR = 4'h1;
	localparam logic [3:0] LOW_CNT_ADDR = 4'h2;
	localparam logic [3:0] HIGH_CNT_ADDR = 4'h3;
	localparam logic [3:0] LOW_PER_ADDR = 4'h4;
	localparam logic [3:0] HIGH_PER_ADDR = 4'h5;
	localparam logic [3:0] IRQ_STATUS_ADDR = 4'h6;
	localparam logic [3:0] IRQ_ENABLE_ADDR = 4'h7;
	localparam logic [3:0] IRQ_CLEAR_ADDR = 4'h8;

	// ------------------------------------------------------------
	// Control register field positions.
	// ------------------------------------------------------------
	localparam int RUN_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int GATE_BIT = 6;
	localparam int PRESCALE_LSB = 4;
	localparam int PAIR_BIT = 3;
	localparam int CLK_SRC_BIT = 1;

	// Implemented bits of each control register.
	localparam logic [15:0] LOW_CTL_MASK = 16'ha07a;
	localparam logic [15:0] HIGH_CTL_MASK = 16'ha072;

	// ------------------------------------------------------------
	// Values after reset.
	// ------------------------------------------------------------
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] PER_RESET = 16'hffff;

	// ------------------------------------------------------------
	// Prescale terminal counts: last count before a tick.
	// ------------------------------------------------------------
	localparam logic [7:0] PS_TERM_1 = 8'h00;
	localparam logic [7:0] PS_TERM_8 = 8'h07;
	localparam logic [7:0] PS_TERM_64 = 8'h3f;
	localparam logic [7:0] PS_TERM_256 = 8'hff;

	// Interrupt status bit positions.
	localparam int LOW_EVT_BIT = 0;
	localparam int HIGH_EVT_BIT = 1;

endpackage

// [ctpr_tick.sv]
// Tick generator for one timer: pin synchronisers, gating, prescaler.
// Assumes clk_sys is the internal half-rate instruction clock.
`timescale 1ns/10ps
module ctpr_tick
#(
	parameter int PS_W = 8
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Effective control for this timer.
	input wire logic run,
	input wire logic idle_stop,
	input wire logic gate_en,
	input wire logic ext_sel,
	input wire logic [1:0] prescale_select,
	input wire logic presc_clear,
	// Device state and pins.
	input wire logic idle_mode,
	input wire logic ext_pin,
	input wire logic gate_pin,
	// Results.
	output logic tick,
	output logic gate_fall
);

	// ------------------------------------------------------------
	// Elaboration checks.
	// ------------------------------------------------------------
	if (PS_W < 8)
	begin : g_bad_width
		$error("Prescale counter must hold 256 counts.");
	end

	// Three-flop chains; the first flop feeds only the second.
	logic [2:0] ext_sync_reg;
	logic [2:0] gate_sync_reg;
	// Accepted levels, updated once stages two and three agree.
	logic ext_lvl_reg;
	logic gate_lvl_reg;
	logic ext_prev_reg;
	logic gate_prev_reg;
	// Prescale counter.
	logic [PS_W-1:0] presc_reg;
	logic [PS_W-1:0] term;
	logic active;
	logic gated;
	logic in_pulse;

	// ------------------------------------------------------------
	// Pin synchronisers and filtered levels.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ext_sync_reg <= 3'h0;
			gate_sync_reg <= 3'h0;
			ext_lvl_reg <= 1'b0;
			gate_lvl_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			gate_prev_reg <= 1'b0;
		end
		else
		begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_pin};
			gate_sync_reg <= {gate_sync_reg[1:0], gate_pin};
			// A change counts only when the last two stages agree.
			if (ext_sync_reg[1] == ext_sync_reg[2])
				ext_lvl_reg <= ext_sync_reg[2];
			if (gate_sync_reg[1] == gate_sync_reg[2])
				gate_lvl_reg <= gate_sync_reg[2];
			ext_prev_reg <= ext_lvl_reg;
			gate_prev_reg <= gate_lvl_reg;
		end
	end

	// ------------------------------------------------------------
	// Input selection, idle halt and gating.
	// ------------------------------------------------------------
	always_comb
	begin
		// Halt in idle only when asked to.
		active = run && !(idle_stop && idle_mode);
		// Gating applies to the internal source only.
		gated = gate_en && !ext_sel;
		if (ext_sel)
			in_pulse = active && ext_lvl_reg && !ext_prev_reg;
		else
			in_pulse = active && (!gated || gate_lvl_reg);
		case (prescale_select)
			2'b00: term = PS_W'(ctpr_pkg::PS_TERM_1);
			2'b01: term = PS_W'(ctpr_pkg::PS_TERM_8);
			2'b10: term = PS_W'(ctpr_pkg::PS_TERM_64);
			default: term = PS_W'(ctpr_pkg::PS_TERM_256);
		endcase
	end

	assign tick = in_pulse && (presc_reg == term);
	// Gate fall raises the event only while gated accumulation runs.
	assign gate_fall = active && gated && gate_prev_reg && !gate_lvl_reg;

	// ------------------------------------------------------------
	// Prescale counter; cleared on stop and on a control write.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			presc_reg <= '0;
		else if (presc_clear || !run)
			presc_reg <= '0;
		else if (tick)
			presc_reg <= '0;
		else if (in_pulse)
			presc_reg <= presc_reg + 1'b1;
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	a_presc_clear_zero: assert property (
		@(posedge clk_sys) disable iff (rst)
		presc_clear |=> presc_reg == '0)
		else $error("Prescaler not cleared after control write.");
	a_idle_halt_tick: assert property (
		@(posedge clk_sys) disable iff (rst)
		(idle_stop && idle_mode) |-> !tick && !gate_fall)
		else $error("Timer advanced while halted in idle.");
	a_ext_gate_ignore: assert property (
		@(posedge clk_sys) disable iff (rst)
		ext_sel |-> !gate_fall)
		else $error("Gate event seen with external clock selected.");

endmodule

// [ctpr_timer_pair.sv]
// Cascadable pair of 16-bit timers with register port and interrupt.
// Assumes a single clk_sys domain; pins arrive asynchronously.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module ctpr_timer_pair
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Device state.
	input wire logic idle_mode,
	// External clock and gate pins.
	input wire logic low_ext_clock_pin,
	input wire logic high_ext_clock_pin,
	input wire logic low_gate_pin,
	input wire logic high_gate_pin,
	// Interrupt.
	output logic irq
);

	// ------------------------------------------------------------
	// Register storage.
	// ------------------------------------------------------------
	// Control registers; only implemented bits are ever stored.
	logic [15:0] low_ctl_reg;
	logic [15:0] high_ctl_reg;
	// Counters and periods.
	logic [15:0] low_cnt_reg;
	logic [15:0] high_cnt_reg;
	logic [15:0] low_per_reg;
	logic [15:0] high_per_reg;
	// Sticky event flags and their enables.
	logic [1:0] status_reg;
	logic [1:0] enable_reg;
	// Read data, valid the cycle after a read strobe.
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	// ------------------------------------------------------------
	// Decoded controls.
	// ------------------------------------------------------------
	// Pair-mode bit of the low control register.
	logic pair;
	// Control per timer; the pair-mode override reaches only the high run_eff.
	logic [15:0] ctl_eff [2];
	logic [1:0] run_eff;
	logic [1:0] presc_clr;
	logic [1:0] tick;
	logic [1:0] gfall;
	logic [1:0] ext_pin;
	logic [1:0] gate_pin;
	// Combined 32-bit count and period views.
	logic [31:0] cnt32;
	logic [31:0] per32;
	logic [31:0] cnt32_inc;
	logic wrap32;
	logic low_match;
	logic high_match;
	logic [1:0] evt;
	logic wr_low_cnt;
	logic wr_high_cnt;

	assign pair = low_ctl_reg[ctpr_pkg::PAIR_BIT];
	// Count and period join high word over low word.
	assign cnt32 = {high_cnt_reg, low_cnt_reg};
	assign per32 = {high_per_reg, low_per_reg};
	assign cnt32_inc = cnt32 + 32'h0000_0001;
	assign wrap32 = (cnt32 == per32);
	assign low_match = (low_cnt_reg == low_per_reg);
	assign high_match = (high_cnt_reg == high_per_reg);
	assign wr_low_cnt = reg_wr && (reg_addr == ctpr_pkg::LOW_CNT_ADDR);
	assign wr_high_cnt = reg_wr && (reg_addr == ctpr_pkg::HIGH_CNT_ADDR);
	assign ext_pin = {high_ext_clock_pin, low_ext_clock_pin};
	assign gate_pin = {high_gate_pin, low_gate_pin};

	// ------------------------------------------------------------
	// Control selection. In pair mode the high control register is
	// ignored entirely and its tick generator is held stopped, so
	// nothing written there can disturb the combined count.
	// ------------------------------------------------------------
	always_comb
	begin
		ctl_eff[0] = low_ctl_reg;
		ctl_eff[1] = high_ctl_reg;
		run_eff[0] = low_ctl_reg[ctpr_pkg::RUN_BIT];
		run_eff[1] = !pair && high_ctl_reg[ctpr_pkg::RUN_BIT];
		// A control write to a running timer restarts its prescaler.
		presc_clr[0] = reg_wr && (reg_addr == ctpr_pkg::LOW_CTL_ADDR)
			&& low_ctl_reg[ctpr_pkg::RUN_BIT];
		presc_clr[1] = reg_wr && (reg_addr == ctpr_pkg::HIGH_CTL_ADDR)
			&& high_ctl_reg[ctpr_pkg::RUN_BIT];
	end

	// ------------------------------------------------------------
	// Tick generators, one per timer.
	// ------------------------------------------------------------
	for (genvar i = 0; i < 2; i++)
	begin : g_tick
		ctpr_tick #(
			.PS_W(8)
		) u_tick (
			.clk_sys(clk_sys),
			.rst(rst),
			.run(run_eff[i]),
			.idle_stop(ctl_eff[i][ctpr_pkg::IDLE_STOP_BIT]),
			.gate_en(ctl_eff[i][ctpr_pkg::GATE_BIT]),
			.ext_sel(ctl_eff[i][ctpr_pkg::CLK_SRC_BIT]),
			.prescale_select(ctl_eff[i][ctpr_pkg::PRESCALE_LSB +: 2]),
			.presc_clear(presc_clr[i]),
			.idle_mode(idle_mode),
			.ext_pin(ext_pin[i]),
			.gate_pin(gate_pin[i]),
			.tick(tick[i]),
			.gate_fall(gfall[i])
		);
	end

	// ------------------------------------------------------------
	// Control registers. Unimplemented bits are masked on write so
	// they always read back as zero.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			low_ctl_reg <= ctpr_pkg::CTL_RESET;
			high_ctl_reg <= ctpr_pkg::CTL_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ctpr_pkg::LOW_CTL_ADDR)
				low_ctl_reg <= reg_wdata & ctpr_pkg::LOW_CTL_MASK;
			if (reg_addr == ctpr_pkg::HIGH_CTL_ADDR)
				high_ctl_reg <= reg_wdata & ctpr_pkg::HIGH_CTL_MASK;
		end
	end

	// ------------------------------------------------------------
	// Period registers.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			low_per_reg <= ctpr_pkg::PER_RESET;
			high_per_reg <= ctpr_pkg::PER_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ctpr_pkg::LOW_PER_ADDR)
				low_per_reg <= reg_wdata;
			if (reg_addr == ctpr_pkg::HIGH_PER_ADDR)
				high_per_reg <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// Low counter. A software write wins over a tick in the same
	// cycle, so a loaded value is never bumped before it is seen.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			low_cnt_reg <= ctpr_pkg::CNT_RESET;
		else if (wr_low_cnt)
			low_cnt_reg <= reg_wdata;
		else if (pair)
		begin
			// Combined counter driven by the low tick only.
			if (tick[0])
				low_cnt_reg <= wrap32 ? 16'h0000 : cnt32_inc[15:0];
		end
		else if (tick[0])
			low_cnt_reg <= low_match ? 16'h0000 : low_cnt_reg + 16'h0001;
	end

	// ------------------------------------------------------------
	// High counter; in pair mode it holds the upper count word.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			high_cnt_reg <= ctpr_pkg::CNT_RESET;
		else if (wr_high_cnt)
			high_cnt_reg <= reg_wdata;
		else if (pair)
		begin
			if (tick[0])
				high_cnt_reg <= wrap32 ? 16'h0000 : cnt32_inc[31:16];
		end
		else if (tick[1])
			high_cnt_reg <= high_match ? 16'h0000 : high_cnt_reg + 16'h0001;
	end

	// ------------------------------------------------------------
	// Events. In pair mode both match and gate fall land on the
	// high flag; the low flag stays quiet.
	// ------------------------------------------------------------
	always_comb
	begin
		if (pair)
		begin
			evt[ctpr_pkg::LOW_EVT_BIT] = 1'b0;
			evt[ctpr_pkg::HIGH_EVT_BIT] = (tick[0] && wrap32) || gfall[0];
		end
		else
		begin
			evt[ctpr_pkg::LOW_EVT_BIT] = (tick[0] && low_match) || gfall[0];
			evt[ctpr_pkg::HIGH_EVT_BIT] = (tick[1] && high_match) || gfall[1];
		end
	end

	// ------------------------------------------------------------
	// Sticky status. A new event beats a clear in the same cycle,
	// so no event is ever lost to a racing acknowledge.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			status_reg <= 2'h0;
		else if (reg_wr && (reg_addr == ctpr_pkg::IRQ_CLEAR_ADDR))
			status_reg <= (status_reg & ~reg_wdata[1:0]) | evt;
		else
			status_reg <= status_reg | evt;
	end

	// Interrupt enable register.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			enable_reg <= 2'h0;
		else if (reg_wr && (reg_addr == ctpr_pkg::IRQ_ENABLE_ADDR))
			enable_reg <= reg_wdata[1:0];
	end

	// Level interrupt while any enabled flag is set.
	assign irq = |(status_reg & enable_reg);

	// ------------------------------------------------------------
	// Read path. Unmapped and write-only addresses read zero.
	// ------------------------------------------------------------
	always_comb
	begin
		case (reg_addr)
			ctpr_pkg::LOW_CTL_ADDR: rdata_next = low_ctl_reg;
			ctpr_pkg::HIGH_CTL_ADDR: rdata_next = high_ctl_reg;
			ctpr_pkg::LOW_CNT_ADDR: rdata_next = low_cnt_reg;
			ctpr_pkg::HIGH_CNT_ADDR: rdata_next = high_cnt_reg;
			ctpr_pkg::LOW_PER_ADDR: rdata_next = low_per_reg;
			ctpr_pkg::HIGH_PER_ADDR: rdata_next = high_per_reg;
			ctpr_pkg::IRQ_STATUS_ADDR: rdata_next = {14'h0000, status_reg};
			ctpr_pkg::IRQ_ENABLE_ADDR: rdata_next = {14'h0000, enable_reg};
			default: rdata_next = 16'h0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata_reg <= 16'h0000;
		else if (reg_rd)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= 16'h0000;
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// A wrap step: tick at the period value with no count write.
	sequence s_pair_wrap;
		pair && tick[0] && wrap32 && !wr_low_cnt && !wr_high_cnt;
	endsequence
	sequence s_pair_zero;
		cnt32 == 32'h0000_0000 && status_reg[ctpr_pkg::HIGH_EVT_BIT];
	endsequence

	a_pair_wrap_flag: assert property (s_pair_wrap |=> s_pair_zero)
		else $error("Combined counter did not wrap and flag.");
	a_pair_count_up: assert property (pair && tick[0] && !wrap32
		&& !wr_low_cnt && !wr_high_cnt
		|=> cnt32 == $past(cnt32) + 32'h0000_0001)
		else $error("Combined counter did not carry into high word.");
	a_pair_high_idle: assert property (pair && !tick[0]
		&& !wr_low_cnt && !wr_high_cnt |=> $stable(cnt32))
		else $error("Combined counter moved without a low tick.");
	a_low_wrap_flag: assert property (!pair && tick[0] && low_match
		&& !wr_low_cnt |=> low_cnt_reg == 16'h0000
		&& status_reg[ctpr_pkg::LOW_EVT_BIT])
		else $error("Low timer did not wrap and flag at period.");
	a_low_stop_hold: assert property (!low_ctl_reg[ctpr_pkg::RUN_BIT]
		&& !wr_low_cnt |=> $stable(low_cnt_reg))
		else $error("Low counter moved while stopped.");
	a_high_stop_hold: assert property (!pair
		&& !high_ctl_reg[ctpr_pkg::RUN_BIT] && !wr_high_cnt
		|=> $stable(high_cnt_reg))
		else $error("High counter moved while stopped.");
	a_ctl_unimpl_zero: assert property ((low_ctl_reg
		& ~ctpr_pkg::LOW_CTL_MASK) == 16'h0000
		&& (high_ctl_reg & ~ctpr_pkg::HIGH_CTL_MASK) == 16'h0000)
		else $error("Unimplemented control bit stored.");
	a_ctl_read_mask: assert property (reg_rd
		&& reg_addr == ctpr_pkg::HIGH_CTL_ADDR
		|=> (reg_rdata & ~ctpr_pkg::HIGH_CTL_MASK) == 16'h0000)
		else $error("Unimplemented control bit read as one.");
	a_pair_low_quiet: assert property (pair && $past(pair)
		&& !(reg_wr && reg_addr == ctpr_pkg::IRQ_CLEAR_ADDR)
		|-> !$rose(status_reg[ctpr_pkg::LOW_EVT_BIT]))
		else $error("Low flag raised in pair mode.");

endmodule

// [ctpr_testbench.sv]
// Self-checking bench for the cascadable timer pair.
// Assumes the design files and the package are compiled first.
`timescale 1ns/10ps
module testbench;

	// ------------------------------------------------------------
	// Stimulus and observation signals.
	// ------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic idle_mode = 1'b0;
	logic low_ext_clock_pin = 1'b0;
	logic high_ext_clock_pin = 1'b0;
	logic low_gate_pin = 1'b0;
	logic high_gate_pin = 1'b0;
	logic irq;
	int error_cnt = 0;
	int tests_run = 0;

	// The device under test; every pin is driven by the bench.
	ctpr_timer_pair dut
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.idle_mode(idle_mode),
		.low_ext_clock_pin(low_ext_clock_pin),
		.high_ext_clock_pin(high_ext_clock_pin),
		.low_gate_pin(low_gate_pin),
		.high_gate_pin(high_gate_pin),
		.irq(irq)
	);

	// The 100 MHz system clock.
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] e, s);
		tests_run++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One-cycle write; it lands at the edge that samples the strobe.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; data stand only in the following cycle.
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Counts advanced over exactly n cycles; phase of the read is moot.
	task automatic span(input logic [3:0] a, input int n,
		output logic [15:0] d);
		logic [15:0] x;
		logic [15:0] y;
		rd(a, x);
		cyc(n - 2);
		rd(a, y);
		d = y - x;
	endtask

	// Waits a bounded time for the interrupt line.
	task automatic wait_irq(input int n);
		int i;
		for (i = 0; i < n && irq !== 1'b1; i++) @(posedge clk_sys);
		#1;
	endtask

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [15:0] d;
		rd(ctpr_pkg::LOW_CTL_ADDR, d);
		chk("low ctl reset", 16'h0000, d);
		rd(ctpr_pkg::HIGH_PER_ADDR, d);
		chk("high period reset", 16'hffff, d);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'hffff);
		rd(ctpr_pkg::LOW_CTL_ADDR, d);
		chk("low ctl mask", 16'ha07a, d);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'hffff);
		rd(ctpr_pkg::HIGH_CTL_ADDR, d);
		chk("high ctl mask", 16'ha072, d);
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h0000);
		wr(4'h9, 16'h1234);
		rd(4'h9, d);
		chk("unmapped read", 16'h0000, d);
		$display("test regs done");
	endtask

	// All four prescale codes, then rewrites that keep clearing it.
	task automatic t_prescale;
		logic [15:0] d;
		logic [15:0] e;
		int c;
		for (c = 0; c < 4; c++)
		begin
			wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8000 | 16'(c << 4));
			span(ctpr_pkg::LOW_CNT_ADDR, 4 << (c * 3 - (c == 3)), d);
			chk("prescaled ticks", 16'h0004, d);
		end
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8010);
		rd(ctpr_pkg::LOW_CNT_ADDR, e);
		// Each rewrite restarts the 1:8 prescaler before it can tick.
		repeat (16) wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8010);
		rd(ctpr_pkg::LOW_CNT_ADDR, d);
		chk("prescaler cleared", 16'h0000, d - e);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		$display("test prescale done");
	endtask

	// Period match, masking and clearing of the interrupt.
	task automatic t_match;
		logic [15:0] d;
		wr(ctpr_pkg::LOW_CNT_ADDR, 16'h0000);
		wr(ctpr_pkg::LOW_PER_ADDR, 16'h0004);
		wr(ctpr_pkg::IRQ_CLEAR_ADDR, 16'h0003);
		wr(ctpr_pkg::IRQ_ENABLE_ADDR, 16'h0001);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8000);
		wait_irq(20);
		chk("match irq", 1'b1, irq);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		rd(ctpr_pkg::LOW_CNT_ADDR, d);
		chk("count bounded", 1'b1, d <= 16'h0004);
		rd(ctpr_pkg::IRQ_STATUS_ADDR, d);
		chk("low status", 16'h0001, d);
		wr(ctpr_pkg::IRQ_ENABLE_ADDR, 16'h0000);
		chk("masked irq", 1'b0, irq);
		wr(ctpr_pkg::IRQ_ENABLE_ADDR, 16'h0001);
		chk("unmasked irq", 1'b1, irq);
		wr(ctpr_pkg::IRQ_CLEAR_ADDR, 16'h0001);
		chk("cleared irq", 1'b0, irq);
		wr(ctpr_pkg::LOW_PER_ADDR, 16'hffff);
		$display("test match done");
	endtask

	// Joined 32-bit timer: carry, joined period, high flag only.
	task automatic t_pair;
		logic [15:0] d;
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0008);
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h8000);
		wr(ctpr_pkg::HIGH_CNT_ADDR, 16'h0000);
		wr(ctpr_pkg::LOW_CNT_ADDR, 16'hfff0);
		wr(ctpr_pkg::HIGH_PER_ADDR, 16'h0001);
		wr(ctpr_pkg::LOW_PER_ADDR, 16'h0010);
		span(ctpr_pkg::HIGH_CNT_ADDR, 16, d);
		chk("high run ignored", 16'h0000, d);
		wr(ctpr_pkg::IRQ_ENABLE_ADDR, 16'h0002);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8008);
		cyc(18);
		rd(ctpr_pkg::HIGH_CNT_ADDR, d);
		chk("carry to high", 16'h0001, d);
		wait_irq(40);
		chk("pair irq", 1'b1, irq);
		rd(ctpr_pkg::IRQ_STATUS_ADDR, d);
		chk("pair status", 16'h0002, d);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::IRQ_CLEAR_ADDR, 16'h0003);
		wr(ctpr_pkg::HIGH_PER_ADDR, 16'hffff);
		wr(ctpr_pkg::LOW_PER_ADDR, 16'hffff);
		$display("test pair done");
	endtask

	// Separate timers, then the idle stop, with pair mode off.
	task automatic t_split_idle;
		logic [15:0] d;
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h8000);
		span(ctpr_pkg::HIGH_CNT_ADDR, 16, d);
		chk("high alone", 16'h0010, d);
		span(ctpr_pkg::LOW_CNT_ADDR, 16, d);
		chk("low stopped", 16'h0000, d);
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'ha000);
		@(posedge clk_sys) idle_mode <= 1'b1;
		span(ctpr_pkg::LOW_CNT_ADDR, 16, d);
		chk("idle halt", 16'h0000, d);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8000);
		span(ctpr_pkg::LOW_CNT_ADDR, 16, d);
		chk("idle run", 16'h0010, d);
		@(posedge clk_sys) idle_mode <= 1'b0;
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		$display("test split done");
	endtask

	// Gated accumulation on the internal clock, and its falling edge.
	task automatic t_gate;
		logic [15:0] d;
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8040);
		span(ctpr_pkg::LOW_CNT_ADDR, 16, d);
		chk("gate closed", 16'h0000, d);
		@(posedge clk_sys) low_gate_pin <= 1'b1;
		cyc(8);
		span(ctpr_pkg::LOW_CNT_ADDR, 16, d);
		chk("gate open", 16'h0010, d);
		@(posedge clk_sys) low_gate_pin <= 1'b0;
		cyc(8);
		rd(ctpr_pkg::IRQ_STATUS_ADDR, d);
		chk("gate fall flag", 16'h0001, d);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::IRQ_CLEAR_ADDR, 16'h0003);
		// The high timer's own gate pin raises its own flag.
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h8040);
		@(posedge clk_sys) high_gate_pin <= 1'b1;
		cyc(8);
		high_gate_pin <= 1'b0;
		cyc(8);
		rd(ctpr_pkg::IRQ_STATUS_ADDR, d);
		chk("high gate fall", 16'h0002, d);
		wr(ctpr_pkg::HIGH_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::IRQ_CLEAR_ADDR, 16'h0003);
		// In pair mode the low gate pin lands on the high flag.
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h8048);
		@(posedge clk_sys) low_gate_pin <= 1'b1;
		cyc(8);
		low_gate_pin <= 1'b0;
		cyc(8);
		rd(ctpr_pkg::IRQ_STATUS_ADDR, d);
		chk("pair gate fall", 16'h0002, d);
		wr(ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		wr(ctpr_pkg::IRQ_CLEAR_ADDR, 16'h0003);
		$display("test gate done");
	endtask

	// External pin edges with the gate enable set and the gate shut.
	task automatic t_ext(input bit hi);
		logic [3:0] ca;
		logic [15:0] a;
		logic [15:0] b;
		ca = hi ? ctpr_pkg::HIGH_CNT_ADDR : ctpr_pkg::LOW_CNT_ADDR;
		wr(hi ? ctpr_pkg::HIGH_CTL_ADDR : ctpr_pkg::LOW_CTL_ADDR, 16'h8042);
		rd(ca, a);
		cyc(1);
		repeat (5)
		begin
			if (hi) high_ext_clock_pin <= 1'b1;
			else low_ext_clock_pin <= 1'b1;
			cyc(4);
			if (hi) high_ext_clock_pin <= 1'b0;
			else low_ext_clock_pin <= 1'b0;
			cyc(4);
		end
		cyc(8);
		rd(ca, b);
		chk("pin edges", 16'h0005, b - a);
		wr(hi ? ctpr_pkg::HIGH_CTL_ADDR : ctpr_pkg::LOW_CTL_ADDR, 16'h0000);
		$display("test external clock done");
	endtask

	// ------------------------------------------------------------
	// Verdict, watchdog and main sequence.
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// The scenarios need under 5000 cycles, so this leaves ample slack.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		error_cnt++;
		finish_test;
	end

	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(4);
		t_regs;
		t_prescale;
		t_match;
		t_pair;
		t_split_idle;
		t_gate;
		t_ext(1'b0);
		t_ext(1'b1);
		finish_test;
	end
endmodule
